//--- rtl/fsrc_pkg.sv
// Types shared by the flash command block.
package fsrc_pkg;
  typedef enum logic [5:0] {
    FR_CMD   = 6'h01,
    FR_ADDR  = 6'h02,
    FR_PARAM = 6'h04,
    FR_DUMMY = 6'h08,
    FR_DATA  = 6'h10,
    FR_SKIP  = 6'h20
  } fsrc_phase_t;
  typedef enum logic [6:0] {
    CS_IDLE  = 7'h01,
    CS_ERASE = 7'h02,
    CS_PROG  = 7'h04,
    CS_OTHER = 7'h08,
    CS_SWAIT = 7'h10,
    CS_SUSP  = 7'h20,
    CS_NEST  = 7'h40
  } fsrc_cstate_t;
  typedef struct packed {
    logic busy;
    logic susp;
    logic qe;
    logic four_line_command_mode;
  } fsrc_stat_t;
  typedef struct packed {
    logic [7:0]  op;
    logic [23:0] addr;
  } fsrc_cmd_t;
  typedef struct packed {
    fsrc_phase_t phase;
    logic [31:0] sr;
    logic [5:0]  cnt;
    logic [3:0]  dcnt;
    logic [2:0]  width;
    logic        fwd;
  } fsrc_frame_t;
  typedef struct packed {
    logic       tgl;
    fsrc_cmd_t  cmd;
    logic [1:0] param;
  } fsrc_keep_t;
  typedef struct packed {
    logic [3:0]  lines;
    logic [3:0]  oe_n;
    logic [7:0]  sh;
    logic [3:0]  rem;
    logic [23:0] addr;
    logic        started;
  } fsrc_out_t;
  typedef struct packed {
    fsrc_cstate_t st;
    logic         busy;
    logic         susp;
    logic         kprog;
    logic         tgl_seen;
    logic         start;
    logic         pause;
    logic         resume;
    logic [9:0]   timer;
    fsrc_cmd_t    cmd;
    fsrc_cmd_t    scmd;
  } fsrc_core_t;
endpackage

//--- rtl/fsrc_regs.svh
// Opcodes, field positions, reset values and timing counts of the flash command block.
// Notes on behaviour
// - Suspend may interrupt sector or block erase, never security erase.
// - Suspend may interrupt page program, never security program.
// - During erase suspend refuse status writes, security program and every erase.
// - Suspend arriving during chip erase is ignored.
// - During program suspend refuse status writes, erases and programs.
// - Suspend accepted only with suspend flag 0 and busy 1 in eligible operation.
// - Program or erase aimed at the suspended sector is ignored.
// - Suspend sets suspend flag at once; busy drops within the suspend latency.
// - Reset leaves the device unsuspended with suspend flag 0.
// - Resume accepted only with suspend flag 1 and busy 0.
// - Resume clears suspend flag at once and sets busy within 200 ns.
// - Basic read takes opcode and 24-bit address on rising clock edges.
// - Read data leaves on falling edges, most significant bit first.
// - Address increments per byte through the array until chip select rises.
// - Basic read issued while busy is ignored.
// - Single-line fast read inserts eight dummy clocks after the address.
// - Four-line fast read dummy count is 4, 6 or 8, default 4.
// - Dual-output read uses eight dummy clocks, then two bits per clock.
// - Quad-output read accepted only with quad enable set, four bits per clock.
`ifndef FSRC_REGS_SVH
`define FSRC_REGS_SVH
`define FSRC_OP_RD    8'h03
`define FSRC_OP_FRD   8'h0B
`define FSRC_OP_DRD   8'h3B
`define FSRC_OP_QRD   8'h6B
`define FSRC_OP_SUS   8'h75
`define FSRC_OP_RES   8'h7A
`define FSRC_OP_PARAM 8'hC0
`define FSRC_OP_PP    8'h02
`define FSRC_OP_QPP   8'h32
`define FSRC_OP_SPP   8'h42
`define FSRC_OP_SE    8'h20
`define FSRC_OP_HBE   8'h52
`define FSRC_OP_BE    8'hD8
`define FSRC_OP_CE1   8'hC7
`define FSRC_OP_CE2   8'h60
`define FSRC_OP_SER   8'h44
`define FSRC_OP_WSR1  8'h01
`define FSRC_OP_WSR2  8'h31
`define FSRC_OP_WSR3  8'h11
`define FSRC_CNT_CMD  6'h08
`define FSRC_CNT_PAR  6'h10
`define FSRC_CNT_ADR  6'h20
`define FSRC_PARAM_LSB 4
`define FSRC_PARAM_RST 2'h0
`define FSRC_SECT_MSB 23
`define FSRC_SECT_LSB 12
`define FSRC_DUMMY_SPI 4'h8
`define FSRC_DUMMY_P0 4'h4
`define FSRC_DUMMY_P1 4'h6
`define FSRC_DUMMY_P2 4'h8
`define FSRC_CLK_NS   40
`define FSRC_SUS_NS   20000
`define FSRC_SUS_CYC  (`FSRC_SUS_NS / `FSRC_CLK_NS)
`define FSRC_RES_NS   200
`define FSRC_RES_CYC  (`FSRC_RES_NS / `FSRC_CLK_NS)
`endif

//--- rtl/fsrc_sync.sv
// Two-flop synchroniser for levels crossing into a clock domain.
`timescale 1ns/1ps
module fsrc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         reset_n_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } fsrc_sync_t;
  fsrc_sync_t s;
  fsrc_sync_t next_s;

  // Only the second stage is visible outside.
  always_comb begin
    next_s.s1 = d_in;
    next_s.s2 = s.s1;
  end

  // Both stages clear to zero under reset.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q_out = s.s2;
endmodule

//--- rtl/fsrc_top.sv
// Flash command sequencer: suspend and resume control plus the read commands.
`timescale 1ns/1ps
`include "fsrc_regs.svh"
module fsrc_top #(
  parameter int MEM_AW  = 24,
  parameter int SUS_CYC = `FSRC_SUS_CYC
) (
  input  wire logic           core_clk_in,
  input  wire logic           reset_n_in,
  input  wire logic           spi_clk_in,
  input  wire logic           cs_n_in,
  input  wire logic           data_line_0_in,
  input  wire logic           data_line_1_in,
  input  wire logic           data_line_2_in,
  input  wire logic           data_line_3_in,
  output logic                data_line_0_out,
  output logic                data_line_1_out,
  output logic                data_line_2_out,
  output logic                data_line_3_out,
  output logic                data_line_0_oe_n_out,
  output logic                data_line_1_oe_n_out,
  output logic                data_line_2_oe_n_out,
  output logic                data_line_3_oe_n_out,
  input  wire logic           quad_enable_flag_in,
  input  wire logic           four_line_command_mode_in,
  input  wire logic           op_done_in,
  output logic                busy_flag_out,
  output logic                suspend_flag_out,
  output logic                op_start_out,
  output logic                op_pause_out,
  output logic                op_resume_out,
  output fsrc_pkg::fsrc_cmd_t op_cmd_out
);
  localparam int SUS_BOUND = SUS_CYC;
  localparam int RES_BOUND = `FSRC_RES_CYC;

  // Refuse sizes that the array index or the latency counter cannot serve.
  if (MEM_AW < 12 || MEM_AW > 24) begin : g_aw_chk
    $error("MEM_AW must lie between 12 and 24");
  end
  if (SUS_CYC < 1 || SUS_CYC > 1000) begin : g_sus_chk
    $error("SUS_CYC must lie between 1 and 1000");
  end

  logic [7:0]            mem [0:(1 << MEM_AW) - 1];
  logic [3:0]            din;
  logic                  link_rst_n;
  logic                  tgl_sync;
  fsrc_pkg::fsrc_stat_t  stat_core;
  fsrc_pkg::fsrc_stat_t  stat_link;
  fsrc_pkg::fsrc_frame_t f;
  fsrc_pkg::fsrc_frame_t next_f;
  fsrc_pkg::fsrc_keep_t  k;
  fsrc_pkg::fsrc_keep_t  next_k;
  fsrc_pkg::fsrc_out_t   o;
  fsrc_pkg::fsrc_out_t   next_o;
  fsrc_pkg::fsrc_core_t  c;
  fsrc_pkg::fsrc_core_t  next_c;
  logic [5:0]            step;
  logic [31:0]           shifted;
  logic                  dec_now;
  logic [23:0]           cur_a;
  logic [7:0]            cur;
  logic                  evt;
  logic                  op_sus;
  logic                  op_res;
  logic                  op_era;
  logic                  op_pp;
  logic                  sect_hit;

  // Array contents stand in for programmed data: each byte holds its address low byte.
  initial begin
    for (int i = 0; i < (1 << MEM_AW); i++) begin
      mem[i] = i[7:0];
    end
  end

  // Chip select high holds the frame logic in reset, so every frame starts clean.
  assign din        = {data_line_3_in, data_line_2_in, data_line_1_in, data_line_0_in};
  assign link_rst_n = reset_n_in & ~cs_n_in;
  assign stat_core  = '{busy: c.busy, susp: c.susp, qe: quad_enable_flag_in,
                        four_line_command_mode: four_line_command_mode_in};

  // The link clock stops between frames, so the first two edges see older status.
  fsrc_sync #(.W(4)) u_stat_sync (
    .clk_in     (spi_clk_in),
    .reset_n_in (reset_n_in),
    .d_in       (stat_core),
    .q_out      (stat_link)
  );

  // Command events cross as a toggle; the held command word is stable by then.
  fsrc_sync #(.W(1)) u_evt_sync (
    .clk_in     (core_clk_in),
    .reset_n_in (reset_n_in),
    .d_in       (k.tgl),
    .q_out      (tgl_sync)
  );

  // Dummy clock count chosen by the read-parameter field.
  function automatic logic [3:0] dummy_of(input logic [1:0] p);
    case (p)
      2'h0:    dummy_of = `FSRC_DUMMY_P0;
      2'h1:    dummy_of = `FSRC_DUMMY_P1;
      default: dummy_of = `FSRC_DUMMY_P2;
    endcase
  endfunction

  // Rising-edge frame decoder: opcode, address, parameter and dummy phases.
  always_comb begin
    next_f  = f;
    next_k  = k;
    step    = stat_link.four_line_command_mode ? 6'h04 : 6'h01;
    shifted = stat_link.four_line_command_mode ? {f.sr[27:0], din} : {f.sr[30:0], din[0]};
    dec_now = 1'b0;
    case (f.phase)
      fsrc_pkg::FR_CMD: begin
        next_f.sr  = shifted;
        next_f.cnt = f.cnt + step;
        if (next_f.cnt == `FSRC_CNT_CMD) begin
          dec_now      = 1'b1;
          next_f.phase = fsrc_pkg::FR_SKIP;
          case (shifted[7:0])
            `FSRC_OP_SUS, `FSRC_OP_RES, `FSRC_OP_CE1, `FSRC_OP_CE2,
            `FSRC_OP_WSR1, `FSRC_OP_WSR2, `FSRC_OP_WSR3: begin
              next_k.tgl = ~k.tgl;
              next_k.cmd = '{op: shifted[7:0], addr: 24'h0};
            end
            `FSRC_OP_PARAM: begin
              if (stat_link.four_line_command_mode) begin
                next_f.phase = fsrc_pkg::FR_PARAM;
              end
            end
            `FSRC_OP_PP, `FSRC_OP_QPP, `FSRC_OP_SPP, `FSRC_OP_SE,
            `FSRC_OP_HBE, `FSRC_OP_BE, `FSRC_OP_SER: begin
              next_f.phase = fsrc_pkg::FR_ADDR;
              next_f.fwd   = 1'b1;
            end
            `FSRC_OP_RD: begin
              if (!stat_link.four_line_command_mode && !stat_link.busy) begin
                next_f.phase = fsrc_pkg::FR_ADDR;
                next_f.width = 3'h1;
                next_f.dcnt  = 4'h0;
              end
            end
            `FSRC_OP_FRD: begin
              if (!stat_link.busy) begin
                next_f.phase = fsrc_pkg::FR_ADDR;
                next_f.width = stat_link.four_line_command_mode ? 3'h4 : 3'h1;
                next_f.dcnt  = stat_link.four_line_command_mode ? dummy_of(k.param) : `FSRC_DUMMY_SPI;
              end
            end
            `FSRC_OP_DRD: begin
              if (!stat_link.four_line_command_mode && !stat_link.busy) begin
                next_f.phase = fsrc_pkg::FR_ADDR;
                next_f.width = 3'h2;
                next_f.dcnt  = `FSRC_DUMMY_SPI;
              end
            end
            `FSRC_OP_QRD: begin
              if (!stat_link.four_line_command_mode && !stat_link.busy && stat_link.qe) begin
                next_f.phase = fsrc_pkg::FR_ADDR;
                next_f.width = 3'h4;
                next_f.dcnt  = `FSRC_DUMMY_SPI;
              end
            end
            default: begin
            end
          endcase
        end
      end
      fsrc_pkg::FR_ADDR: begin
        next_f.sr  = shifted;
        next_f.cnt = f.cnt + step;
        if (next_f.cnt == `FSRC_CNT_ADR) begin
          if (f.fwd) begin
            next_k.tgl   = ~k.tgl;
            next_k.cmd   = '{op: shifted[31:24], addr: shifted[23:0]};
            next_f.phase = fsrc_pkg::FR_SKIP;
          end else if (f.dcnt == 4'h0) begin
            next_f.phase = fsrc_pkg::FR_DATA;
          end else begin
            next_f.phase = fsrc_pkg::FR_DUMMY;
          end
        end
      end
      fsrc_pkg::FR_PARAM: begin
        next_f.sr  = shifted;
        next_f.cnt = f.cnt + step;
        if (next_f.cnt == `FSRC_CNT_PAR) begin
          next_k.param = shifted[`FSRC_PARAM_LSB +: 2];
          next_f.phase = fsrc_pkg::FR_SKIP;
        end
      end
      fsrc_pkg::FR_DUMMY: begin
        next_f.dcnt = f.dcnt - 4'h1;
        if (f.dcnt == 4'h1) begin
          next_f.phase = fsrc_pkg::FR_DATA;
        end
      end
      default: begin
      end
    endcase
  end

  // Frame state dies with chip select; the kept state lives across frames.
  always_ff @(posedge spi_clk_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      f <= '{phase: fsrc_pkg::FR_CMD, default: '0};
    end else begin
      f <= next_f;
    end
  end

  always_ff @(posedge spi_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      k <= '{param: `FSRC_PARAM_RST, default: '0};
    end else begin
      k <= next_k;
    end
  end

  // Falling-edge shifter; a fresh byte is fetched whenever the last one ran out.
  always_comb begin
    next_o = o;
    cur_a  = o.started ? o.addr : f.sr[23:0];
    cur    = (o.rem == 4'h0) ? mem[cur_a[MEM_AW-1:0]] : o.sh;
    if (f.phase == fsrc_pkg::FR_DATA) begin
      next_o.started = 1'b1;
      if (o.rem == 4'h0) begin
        next_o.addr = cur_a + 24'h1;
      end
      next_o.sh  = cur << f.width;
      next_o.rem = ((o.rem == 4'h0) ? 4'h8 : o.rem) - {1'b0, f.width};
      case (f.width)
        3'h1: begin
          next_o.lines = {2'b00, cur[7], 1'b0};
          next_o.oe_n  = 4'hD;
        end
        3'h2: begin
          next_o.lines = {2'b00, cur[7:6]};
          next_o.oe_n  = 4'hC;
        end
        default: begin
          next_o.lines = cur[7:4];
          next_o.oe_n  = 4'h0;
        end
      endcase
    end
  end

  always_ff @(negedge spi_clk_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      o <= '{oe_n: 4'hF, default: '0};
    end else begin
      o <= next_o;
    end
  end

  // Core sequencer for busy and suspend; the engine reports completion.
  always_comb begin
    next_c          = c;
    evt             = tgl_sync ^ c.tgl_seen;
    op_sus          = evt && (k.cmd.op == `FSRC_OP_SUS);
    op_res          = evt && (k.cmd.op == `FSRC_OP_RES);
    op_era          = k.cmd.op inside {`FSRC_OP_SE, `FSRC_OP_HBE, `FSRC_OP_BE};
    op_pp           = k.cmd.op inside {`FSRC_OP_PP, `FSRC_OP_QPP};
    sect_hit        = k.cmd.addr[`FSRC_SECT_MSB:`FSRC_SECT_LSB] ==
                      c.scmd.addr[`FSRC_SECT_MSB:`FSRC_SECT_LSB];
    next_c.tgl_seen = tgl_sync;
    next_c.start    = 1'b0;
    next_c.pause    = 1'b0;
    next_c.resume   = 1'b0;
    case (c.st)
      fsrc_pkg::CS_IDLE: begin
        if (evt && !op_sus && !op_res) begin
          next_c.start = 1'b1;
          next_c.busy  = 1'b1;
          next_c.cmd   = k.cmd;
          next_c.st    = op_era ? fsrc_pkg::CS_ERASE :
                         op_pp ? fsrc_pkg::CS_PROG : fsrc_pkg::CS_OTHER;
        end
      end
      fsrc_pkg::CS_ERASE, fsrc_pkg::CS_PROG: begin
        if (op_done_in) begin
          next_c.busy = 1'b0;
          next_c.st   = fsrc_pkg::CS_IDLE;
        end else if (op_sus) begin
          next_c.susp  = 1'b1;
          next_c.pause = 1'b1;
          next_c.kprog = (c.st == fsrc_pkg::CS_PROG);
          next_c.scmd  = c.cmd;
          next_c.timer = 10'(SUS_CYC - 1);
          next_c.st    = fsrc_pkg::CS_SWAIT;
        end
      end
      fsrc_pkg::CS_OTHER: begin
        if (op_done_in) begin
          next_c.busy = 1'b0;
          next_c.st   = fsrc_pkg::CS_IDLE;
        end
      end
      fsrc_pkg::CS_SWAIT: begin
        if (c.timer == 10'h000) begin
          next_c.busy = 1'b0;
          next_c.st   = fsrc_pkg::CS_SUSP;
        end else begin
          next_c.timer = c.timer - 10'h001;
        end
      end
      fsrc_pkg::CS_SUSP: begin
        if (op_res) begin
          next_c.susp   = 1'b0;
          next_c.busy   = 1'b1;
          next_c.resume = 1'b1;
          next_c.cmd    = c.scmd;
          next_c.st     = c.kprog ? fsrc_pkg::CS_PROG : fsrc_pkg::CS_ERASE;
        end else if (evt && !c.kprog && op_pp && !sect_hit) begin
          next_c.start = 1'b1;
          next_c.busy  = 1'b1;
          next_c.cmd   = k.cmd;
          next_c.st    = fsrc_pkg::CS_NEST;
        end
      end
      fsrc_pkg::CS_NEST: begin
        if (op_done_in) begin
          next_c.busy = 1'b0;
          next_c.st   = fsrc_pkg::CS_SUSP;
        end
      end
      default: begin
        next_c.st = fsrc_pkg::CS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      c <= '{st: fsrc_pkg::CS_IDLE, default: '0};
    end else begin
      c <= next_c;
    end
  end

  assign data_line_0_out      = o.lines[0];
  assign data_line_1_out      = o.lines[1];
  assign data_line_2_out      = o.lines[2];
  assign data_line_3_out      = o.lines[3];
  assign data_line_0_oe_n_out = o.oe_n[0];
  assign data_line_1_oe_n_out = o.oe_n[1];
  assign data_line_2_oe_n_out = o.oe_n[2];
  assign data_line_3_oe_n_out = o.oe_n[3];
  assign busy_flag_out        = c.busy;
  assign suspend_flag_out     = c.susp;
  assign op_start_out         = c.start;
  assign op_pause_out         = c.pause;
  assign op_resume_out        = c.resume;
  assign op_cmd_out           = c.cmd;

  sus_take_a: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    op_sus && !op_done_in && (c.st inside {fsrc_pkg::CS_ERASE, fsrc_pkg::CS_PROG})
    |=> c.susp && c.busy && c.pause)
    else $error("suspend not taken");

  sus_busy_a: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    $rose(c.susp) |-> ##[1:SUS_BOUND] !c.busy)
    else $error("busy not cleared within suspend latency");

  chip_nosus_a: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    c.st == fsrc_pkg::CS_OTHER && op_sus |=> !c.susp)
    else $error("suspend taken during unsuspendable operation");

  res_busy_a: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    c.st == fsrc_pkg::CS_SUSP && op_res |=> !c.susp ##0 (##[0:RES_BOUND] c.busy))
    else $error("resume did not clear suspend or raise busy in time");

  res_skip_a: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    op_res && !(c.susp && !c.busy) |=> $stable(c.susp))
    else $error("resume taken outside suspended state");

  esus_ref_a: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    c.st == fsrc_pkg::CS_SUSP && !c.kprog && evt && !(op_pp && !sect_hit)
    |=> !c.start)
    else $error("forbidden command started during erase suspend");

  psus_ref_a: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    c.st == fsrc_pkg::CS_SUSP && c.kprog && evt |=> !c.start)
    else $error("command started during program suspend");

  rd_busy_a: assert property (
    @(posedge spi_clk_in) disable iff (!link_rst_n)
    dec_now && shifted[7:0] == `FSRC_OP_RD && stat_link.busy
    |=> f.phase == fsrc_pkg::FR_SKIP)
    else $error("basic read accepted while busy");

  frd_dummy_a: assert property (
    @(posedge spi_clk_in) disable iff (!link_rst_n)
    dec_now && shifted[7:0] == `FSRC_OP_FRD && !stat_link.busy
    |=> f.dcnt == (stat_link.four_line_command_mode ? dummy_of(k.param) : `FSRC_DUMMY_SPI))
    else $error("fast read dummy count wrong");

  qrd_gate_a: assert property (
    @(posedge spi_clk_in) disable iff (!link_rst_n)
    dec_now && shifted[7:0] == `FSRC_OP_QRD && !stat_link.qe
    |=> f.phase == fsrc_pkg::FR_SKIP)
    else $error("quad read accepted without quad enable");
endmodule

//--- testbench/fsrc_host.sv
// Host serial flash controller model: frames at 30 ns and samples the replies.
`timescale 1ns/1ps
module fsrc_host (
  output logic            spi_clk_out,
  output logic            cs_n_out,
  output logic      [3:0] drv_out,
  input  wire logic [3:0] oe_n_in,
  input  wire logic [3:0] line_in,
  output logic      [7:0] rx_out,
  output logic            rx_stb_out,
  output logic            drove_out
);
  logic [3:0] held;
  logic [3:0] smp;
  initial begin
    spi_clk_out = 0;
    cs_n_out = 1;
    drv_out = '0;
    held = '0;
    rx_stb_out = 0;
    drove_out = 0;
  end
  // Any device drive inside a frame is noted for refusal checks.
  always @(oe_n_in) if (!cs_n_out && oe_n_in !== 4'hF) drove_out = 1;
  // One clock period; released lines flip so a stale level never passes.
  task automatic tick(input bit rel);
    #15 spi_clk_out = 1;
    smp = line_in;
    if (rel) held = '0;
    #15 spi_clk_out = 0;
    drv_out = drv_out ^ ~held;
  endtask
  task automatic kick(input int n);
    repeat (n) tick(0);
  endtask
  // Clock stands still between frames, as a real controller leaves it.
  task automatic frame(input logic [31:0] oa, input int na, input int nd,
                       input int w, input int nb, input logic [31:0] r, input bit q);
    logic [7:0] b;
    drove_out = 0;
    held = q ? 4'hF : 4'h1;
    cs_n_out = 0;
    // opcode address msb, nibbles in four-line mode
    for (int i = 0; i < 8 + na; i += q ? 4 : 1) begin
      if (q) drv_out = oa[31-i -: 4];
      else drv_out[0] = oa[31-i];
      tick(0);
    end
    for (int i = 0; i < nd; i++) begin
      drv_out[0] = r[i];
      tick(w > 1 && i == nd - 1);
    end
    for (int k = 0; k < nb; k++) begin
      for (int j = 0; j < 8 / w; j++) begin
        tick(0);
        b = w == 4 ? {b[3:0], smp} : w == 2 ? {b[5:0], smp[1:0]} : {b[6:0], smp[1]};
      end
      rx_out = b;
      rx_stb_out = 1;
      #1 rx_stb_out = 0;
    end
    #15 cs_n_out = 1;
    held = '0;
    #30;
  endtask
endmodule

//--- testbench/fsrc_top_test.sv
// Bench for the flash command block: reads, suspend and resume via a host model.
`timescale 1ns/1ps
module fsrc_top_test;
  localparam int SUSPEND_FLAG = 4;
  localparam logic [31:0] BAD [11] = '{32'h20002000, 32'h52002000, 32'hD8002000,
    32'hC7000000, 32'h60000000, 32'h44001000, 32'h01000000, 32'h31000000,
    32'h11000000, 32'h42002000, 32'h02001010};
  logic                clk, rst_n, qe, done, sclk, cs_n, busy, susp, start, stb, drove;
  logic                four_line_command_mode, pause, resume;
  logic [3:0]          dout, oe_n, drv, line;
  logic [7:0]          rx;
  fsrc_pkg::fsrc_cmd_t cmd;
  logic [7:0]          exq [$];
  logic [31:0]         seed = 32'h7F6C4A8D;
  int                  mismatches = 0;
  int                  tests_run = 0;
  int                  n;
  // Device drive wins; otherwise the host level is on the wire.
  assign line = (dout & ~oe_n) | (drv & oe_n);
  fsrc_top #(.MEM_AW(12), .SUS_CYC(SUSPEND_FLAG)) dut (
    .core_clk_in(clk), .reset_n_in(rst_n), .spi_clk_in(sclk), .cs_n_in(cs_n),
    .data_line_0_in(line[0]), .data_line_1_in(line[1]), .data_line_2_in(line[2]),
    .data_line_3_in(line[3]), .data_line_0_out(dout[0]), .data_line_1_out(dout[1]),
    .data_line_2_out(dout[2]), .data_line_3_out(dout[3]), .data_line_0_oe_n_out(oe_n[0]),
    .data_line_1_oe_n_out(oe_n[1]), .data_line_2_oe_n_out(oe_n[2]),
    .data_line_3_oe_n_out(oe_n[3]), .quad_enable_flag_in(qe),
    .four_line_command_mode_in(four_line_command_mode), .op_done_in(done), .busy_flag_out(busy),
    .suspend_flag_out(susp), .op_start_out(start), .op_pause_out(pause),
    .op_resume_out(resume), .op_cmd_out(cmd));
  fsrc_host host (.spi_clk_out(sclk), .cs_n_out(cs_n), .drv_out(drv), .oe_n_in(oe_n),
    .line_in(line), .rx_out(rx), .rx_stb_out(stb), .drove_out(drove));
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return start;
      1: return susp;
      2: return !busy;
      3: return busy;
      default: return !susp;
    endcase
  endfunction
  // Counts core cycles until the event; a required one that never comes ends the run.
  task automatic waitk(input int k, input int lim, input bit must);
    n = 0;
    while (sig(k) !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
    if (must && sig(k) !== 1'b1) begin
      mismatches++;
      $display("mismatch wait %0d expected 1 seen 0", k);
      summarize();
    end
  endtask
  task automatic send(input logic [31:0] oa, input int na);
    host.frame(oa, na, 0, 1, 0, 0, four_line_command_mode);
  endtask
  // Mode pins change just after a core edge; two link edges let the device see them.
  task automatic mode(input bit e, input bit p);
    @(posedge clk);
    #1 qe = e;
    four_line_command_mode = p;
    host.kick(2);
  endtask
  task automatic rd(input logic [7:0] op, input int nd, input int w, input bit ok);
    logic [23:0] a;
    a = 24'(rnd());
    for (int i = 0; i < 3 && ok; i++) exq.push_back(8'(a + i));
    host.frame({op, a}, 24, nd, w, ok ? 3 : 0, rnd(), four_line_command_mode);
    chk("device drive", 32'(ok), 32'(drove));
  endtask
  task automatic fin_op();
    @(posedge clk);
    #1 done = 1;
    @(posedge clk);
    #1 done = 0;
    waitk(2, 5, 1);
  endtask
  task automatic do_reset();
    #1 rst_n = 0;
    fork
      host.kick(3);
      repeat (3) @(posedge clk);
    join
    #1 rst_n = 1;
    repeat (2) @(posedge clk);
    host.kick(2);
    chk("reset state", 32'h0F, {busy, susp, oe_n});
  endtask
  // Each reply byte is compared with the oldest note.
  always @(posedge stb)
    if (exq.size() == 0) chk("spare byte", 32'h100, rx);
    else chk("read byte", exq.pop_front(), rx);
  // Reads first, then erase and program suspension with their refusals.
  initial begin
    rst_n = 0;
    qe = 0;
    four_line_command_mode = 0;
    done = 0;
    do_reset();
    rd(8'h03, 0, 1, 1);
    rd(8'h0B, 8, 1, 1);
    rd(8'h3B, 8, 2, 1);
    mode(1, 0);
    rd(8'h6B, 8, 4, 1);
    mode(0, 0);
    rd(8'h6B, 8, 4, 0);
    mode(0, 1);
    rd(8'h0B, 4, 4, 1);
    send(32'hC0100000, 8);
    rd(8'h0B, 6, 4, 1);
    mode(0, 0);
    send(32'h20001000, 24);
    waitk(0, 20, 1);
    chk("erase cmd", 32'h20001000, cmd);
    rd(8'h03, 0, 1, 0);
    send(32'h75000000, 0);
    waitk(1, 20, 1);
    chk("pause pulse", 1, pause);
    waitk(2, 20, 1);
    chk("suspend latency", SUSPEND_FLAG, n);
    foreach (BAD[i]) begin
      send(BAD[i], 24);
      waitk(0, 20, 0);
      chk("refused op", 20, n);
    end
    rd(8'h03, 0, 1, 1);
    send(32'h02002000, 24);
    waitk(0, 20, 1);
    fin_op();
    send(32'h7A000000, 0);
    waitk(4, 20, 1);
    chk("resume pulse", 1, resume);
    waitk(3, 5, 1);
    chk("resume cmd", 32'h20001000, cmd);
    fin_op();
    send(32'h7A000000, 0);
    waitk(3, 20, 0);
    chk("idle resume", 20, n);
    send(32'h75000000, 0);
    waitk(1, 20, 0);
    chk("idle suspend", 20, n);
    send(32'hC7000000, 0);
    waitk(0, 20, 1);
    send(32'h75000000, 0);
    waitk(1, 20, 0);
    chk("chip erase suspend", 20, n);
    fin_op();
    send(32'h02001000, 24);
    waitk(0, 20, 1);
    send(32'h75000000, 0);
    waitk(1, 20, 1);
    send(32'h20002000, 24);
    waitk(0, 20, 0);
    chk("erase in program suspend", 20, n);
    rd(8'h03, 0, 1, 1);
    do_reset();
    mode(0, 1);
    rd(8'h0B, 4, 4, 1);
    chk("bytes left", 0, exq.size());
    summarize();
  end
endmodule
